/* File: pkg/acdrpg_pkg.sv */
// Shared constants and types for the auxiliary clock divider and frame reference pulse generator.
package acdrpg_pkg;

   // Avalon-MM slave geometry.
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;

   // Register byte offsets.
   localparam logic [5:0] OFF_CTRL = 6'h00;
   localparam logic [5:0] OFF_AUXDIV = 6'h04;
   localparam logic [5:0] OFF_REFDIV = 6'h08;
   localparam logic [5:0] OFF_BURST = 6'h0C;
   localparam logic [5:0] OFF_DELAY = 6'h10;
   localparam logic [5:0] OFF_STATUS = 6'h14;

   // Field widths.
   localparam int MODE_W = 2;
   localparam int PRE_W = 2;
   localparam int POST_W = 10;
   localparam int REF_W = 14;
   localparam int CNT_W = 4;
   localparam int DLY_W = 4;
   localparam int DLY_DEPTH = 16;

   // Field positions.
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_FORCE_BIT = 2;
   localparam int CTRL_BYP_BIT = 3;
   localparam int CTRL_SYNC_BIT = 4;
   localparam int AUX_PRE_LSB = 0;
   localparam int AUX_POST_LSB = 16;
   localparam int REF_DIV_LSB = 0;
   localparam int BURST_CNT_LSB = 0;
   localparam int DLY_MAIN_LSB = 0;
   localparam int DLY_AUX_LSB = 8;
   localparam int ST_REQ_BIT = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_GEN_BIT = 2;
   localparam int ST_AUXCLK_BIT = 3;

   // Reset values.
   localparam logic [1:0] MODE_DEF = 2'h0;
   localparam logic [1:0] PRE_DEF = 2'h2;
   localparam logic [9:0] POST_DEF = 10'h020;
   localparam logic [13:0] REF_DEF = 14'h0040;
   localparam logic [3:0] CNT_DEF = 4'h0;
   localparam logic [3:0] DLY_DEF = 4'h0;

   // Prescaler codes.
   localparam logic [1:0] PRE_CODE_1 = 2'h0;
   localparam logic [1:0] PRE_CODE_2 = 2'h1;
   localparam logic [2:0] PRE_RATIO_1 = 3'h1;
   localparam logic [2:0] PRE_RATIO_2 = 3'h2;
   localparam logic [2:0] PRE_RATIO_4 = 3'h4;

   typedef enum logic [1:0] {MODE_GEN, MODE_BURST, MODE_REPEAT, MODE_RSVD} acdrpg_mode_type;
   typedef enum logic [1:0] {BR_IDLE, BR_WAIT, BR_RUN} acdrpg_burst_type;

   // Codes other than 0 and 1 select divide by 4.
   function automatic logic [2:0] pre_ratio(input logic [1:0] code);
      case (code)
         PRE_CODE_1: pre_ratio = PRE_RATIO_1;
         PRE_CODE_2: pre_ratio = PRE_RATIO_2;
         default: pre_ratio = PRE_RATIO_4;
      endcase
   endfunction

endpackage

/* File: logic/acdrpg_div.sv */
// Programmable counter divider with period tick and duty-cycle level output.
`timescale 1ns/1ps
`default_nettype none
module acdrpg_div #(
   parameter int W = 10
) (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // Control.
   input wire logic i_en,
   input wire logic i_clr,
   input wire logic [W-1:0] i_ratio,
   // Outputs.
   output logic o_tick,
   output logic o_level
);

   if (W < 2) begin : g_chk
      $error("acdrpg_div needs W of at least 2");
   end

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic next_level;
   logic [W-1:0] ratio;
   logic [W-1:0] last;
   logic [W-1:0] high_len;

   // A ratio of zero is served as one; odd ratios keep the longer half high.
   always_comb begin
      ratio = (i_ratio == '0) ? W'(1) : i_ratio;
      last = ratio - W'(1);
      high_len = ratio - (ratio >> 1);
      o_tick = i_en && !i_clr && (cnt >= last);
      next_cnt = cnt;
      if (i_clr) begin
         next_cnt = '0; // [R3]
      end else if (i_en) begin
         next_cnt = (cnt >= last) ? '0 : cnt + W'(1);
      end
      next_level = (next_cnt < high_len); // [R2]
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= '0;
         o_level <= 1'b0;
      end else begin
         cnt <= next_cnt;
         o_level <= next_level;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   property p_wrap_rises;
      (o_tick && i_ratio > W'(1)) |=> o_level;
   endproperty
   a_wrap_rises: assert property (p_wrap_rises) else $error("level not high after wrap"); // [R2]

   property p_even_half;
      (i_en && !i_clr && i_ratio == W'(2) && cnt == '0) |=> !o_level;
   endproperty
   a_even_half: assert property (p_even_half) else $error("divide by two not 50 percent"); // [R2]

   property p_clear;
      i_clr |=> (cnt == '0) && o_level;
   endproperty
   a_clear: assert property (p_clear) else $error("sync did not realign divider"); // [R3]

endmodule // acdrpg_div
`default_nettype wire

/* File: logic/acdrpg_top.sv */
// Auxiliary clock divider chain and frame reference generator, pulser and repeater with Avalon-MM registers.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

// Behaviour
// [R1] Software keeps prescaler output at most 3.2 GHz.
// [R2] Odd post ratios give non-50 percent duty.
// [R3] Sync event realigns prescaler and post-divider.
// [R4] Reset: prescaler divides 4, post-divider 32.
// [R5] Mode 0 emits continuous periodic reference pulses.
// [R6] Gating in mode 0 never stops dividers.
// [R7] Mode 0 outputs only while request high.
// [R8] Mode 1 emits burst of 1..16 pulses.
// [R9] Burst starts on pin or force rise.
// [R10] Mode 2 resamples request pins as output.
// [R11] Repeater output passes the selected delay path.
// [R12] Reference retimed to its companion output clock.
// [R13] One generator feeds main and auxiliary outputs.
// [R14] Clock to reference offset is software adjustable.
// [R15] Pins held low before using force bit.
// [R16] Software picks valid level and common mode.
// [R17] Request pins synchronised before edge detection.
module acdrpg_top
   import acdrpg_pkg::*;
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // Avalon-MM slave.
   input wire logic [acdrpg_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [acdrpg_pkg::DATA_W-1:0] i_avs_writedata,
   output logic [acdrpg_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Request pins and external synchronization event.
   input wire logic i_frame_ref_request_pins,
   input wire logic i_sync_event,
   // Clock and reference outputs.
   output logic o_aux_fabric_clock,
   output logic o_main_frame_ref,
   output logic o_aux_frame_ref
);
   import acdrpg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic ack;
   logic next_ack;
   logic [DATA_W-1:0] next_rdata;
   logic [MODE_W-1:0] frame_ref_mode_select;
   logic [MODE_W-1:0] next_mode;
   logic frame_ref_request_force;
   logic next_force;
   logic frame_ref_delay_bypass;
   logic next_byp;
   logic sw_sync;
   logic next_sw_sync;
   logic [PRE_W-1:0] aux_prescaler;
   logic [PRE_W-1:0] next_pre;
   logic [POST_W-1:0] aux_post_divider;
   logic [POST_W-1:0] next_post;
   logic [REF_W-1:0] ref_divider;
   logic [REF_W-1:0] next_refdiv;
   logic [CNT_W-1:0] burst_pulse_count;
   logic [CNT_W-1:0] next_cnt;
   logic [DLY_W-1:0] dly_main;
   logic [DLY_W-1:0] next_dly_main;
   logic [DLY_W-1:0] dly_aux;
   logic [DLY_W-1:0] next_dly_aux;
   logic wr_take;
   logic burst_busy;
   logic req_s2;
   logic gen_level;

   // The request is answered one cycle late so read data come from a flip-flop.
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;
   assign wr_take = i_avs_write && ack;

   always_comb begin
      next_ack = (i_avs_read || i_avs_write) && !ack;
      next_rdata = o_avs_readdata;
      next_mode = frame_ref_mode_select;
      next_force = frame_ref_request_force;
      next_byp = frame_ref_delay_bypass;
      next_sw_sync = 1'b0;
      next_pre = aux_prescaler;
      next_post = aux_post_divider;
      next_refdiv = ref_divider;
      next_cnt = burst_pulse_count;
      next_dly_main = dly_main;
      next_dly_aux = dly_aux;
      if (i_avs_read && !ack) begin
         next_rdata = '0;
         case (i_avs_address)
            OFF_CTRL: begin
               next_rdata[CTRL_MODE_LSB +: MODE_W] = frame_ref_mode_select;
               next_rdata[CTRL_FORCE_BIT] = frame_ref_request_force;
               next_rdata[CTRL_BYP_BIT] = frame_ref_delay_bypass;
            end
            OFF_AUXDIV: begin
               next_rdata[AUX_PRE_LSB +: PRE_W] = aux_prescaler;
               next_rdata[AUX_POST_LSB +: POST_W] = aux_post_divider;
            end
            OFF_REFDIV: next_rdata[REF_DIV_LSB +: REF_W] = ref_divider;
            OFF_BURST: next_rdata[BURST_CNT_LSB +: CNT_W] = burst_pulse_count;
            OFF_DELAY: begin
               next_rdata[DLY_MAIN_LSB +: DLY_W] = dly_main;
               next_rdata[DLY_AUX_LSB +: DLY_W] = dly_aux;
            end
            OFF_STATUS: begin
               next_rdata[ST_REQ_BIT] = req_s2;
               next_rdata[ST_BUSY_BIT] = burst_busy;
               next_rdata[ST_GEN_BIT] = gen_level;
               next_rdata[ST_AUXCLK_BIT] = o_aux_fabric_clock;
            end
            default: next_rdata = '0;
         endcase
      end
      if (wr_take) begin
         case (i_avs_address)
            OFF_CTRL: begin
               next_mode = i_avs_writedata[CTRL_MODE_LSB +: MODE_W];
               next_force = i_avs_writedata[CTRL_FORCE_BIT];
               next_byp = i_avs_writedata[CTRL_BYP_BIT];
               next_sw_sync = i_avs_writedata[CTRL_SYNC_BIT];
            end
            OFF_AUXDIV: begin
               next_pre = i_avs_writedata[AUX_PRE_LSB +: PRE_W];
               next_post = i_avs_writedata[AUX_POST_LSB +: POST_W];
            end
            OFF_REFDIV: next_refdiv = i_avs_writedata[REF_DIV_LSB +: REF_W];
            OFF_BURST: next_cnt = i_avs_writedata[BURST_CNT_LSB +: CNT_W];
            OFF_DELAY: begin
               next_dly_main = i_avs_writedata[DLY_MAIN_LSB +: DLY_W]; // [R14]
               next_dly_aux = i_avs_writedata[DLY_AUX_LSB +: DLY_W]; // [R14]
            end
            default: next_ack = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ack <= 1'b0;
         o_avs_readdata <= '0;
         frame_ref_mode_select <= MODE_DEF;
         frame_ref_request_force <= 1'b0;
         frame_ref_delay_bypass <= 1'b0;
         sw_sync <= 1'b0;
         aux_prescaler <= PRE_DEF; // [R4]
         aux_post_divider <= POST_DEF; // [R4]
         ref_divider <= REF_DEF;
         burst_pulse_count <= CNT_DEF;
         dly_main <= DLY_DEF;
         dly_aux <= DLY_DEF;
      end else begin
         ack <= next_ack;
         o_avs_readdata <= next_rdata;
         frame_ref_mode_select <= next_mode;
         frame_ref_request_force <= next_force;
         frame_ref_delay_bypass <= next_byp;
         sw_sync <= next_sw_sync;
         aux_prescaler <= next_pre;
         aux_post_divider <= next_post;
         ref_divider <= next_refdiv;
         burst_pulse_count <= next_cnt;
         dly_main <= next_dly_main;
         dly_aux <= next_dly_aux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Divider chain. The sync event clears every divider together.

   logic sync_evt;
   logic pre_tick;
   logic post_tick;
   logic gen_tick;

   assign sync_evt = sw_sync || i_sync_event;

   acdrpg_div #(.W(3)) u_pre (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_en(1'b1),
      .i_clr(sync_evt), // [R3]
      .i_ratio(pre_ratio(aux_prescaler)),
      .o_tick(pre_tick),
      .o_level()
   );

   acdrpg_div #(.W(POST_W)) u_post (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_en(pre_tick),
      .i_clr(sync_evt), // [R3]
      .i_ratio(aux_post_divider),
      .o_tick(post_tick),
      .o_level(o_aux_fabric_clock)
   );

   // The generator divider runs free in every mode so gating never costs alignment.
   acdrpg_div #(.W(REF_W)) u_gen (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_en(1'b1), // [R6]
      .i_clr(sync_evt),
      .i_ratio(ref_divider),
      .o_tick(gen_tick),
      .o_level(gen_level)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Request synchroniser and burst sequencer.

   logic req_s1;
   logic req_s3;
   logic force_q;
   logic req_rise;
   logic launch;
   acdrpg_burst_type burst_state;
   acdrpg_burst_type next_state;
   logic [CNT_W:0] remain;
   logic [CNT_W:0] next_remain;

   // Only the second and third stages are looked at, never the first.
   assign req_rise = req_s2 && !req_s3; // [R17]
   assign launch = req_rise || (frame_ref_request_force && !force_q && !req_s2); // [R9]
   assign burst_busy = (burst_state != BR_IDLE);

   always_comb begin
      next_state = burst_state;
      next_remain = remain;
      case (burst_state)
         BR_IDLE: begin
            if (frame_ref_mode_select == MODE_BURST && launch) begin
               next_state = BR_WAIT; // [R9]
            end
         end
         BR_WAIT: begin
            if (gen_tick) begin
               next_state = BR_RUN;
               next_remain = {1'b0, burst_pulse_count} + (CNT_W + 1)'(1); // [R8]
            end
         end
         BR_RUN: begin
            if (gen_tick) begin
               next_remain = remain - (CNT_W + 1)'(1);
               if (remain == (CNT_W + 1)'(1)) begin
                  next_state = BR_IDLE; // [R8]
               end
            end
         end
         default: next_state = BR_IDLE;
      endcase
      if (frame_ref_mode_select != MODE_BURST || sync_evt) begin
         next_state = BR_IDLE;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
         force_q <= 1'b0;
         burst_state <= BR_IDLE;
         remain <= '0;
      end else begin
         req_s1 <= i_frame_ref_request_pins; // [R17]
         req_s2 <= req_s1;
         req_s3 <= req_s2;
         force_q <= frame_ref_request_force;
         burst_state <= next_state;
         remain <= next_remain;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode mux, delay path and retiming to each output clock.

   logic raw;
   logic next_raw;
   logic [DLY_DEPTH-1:0] dly_line;
   logic [DLY_DEPTH-1:0] next_line;
   logic next_main;
   logic next_aux;

   always_comb begin
      case (frame_ref_mode_select)
         MODE_GEN: next_raw = gen_level && (req_s2 || frame_ref_request_force); // [R5] [R7]
         MODE_BURST: next_raw = gen_level && (burst_state == BR_RUN); // [R8]
         MODE_REPEAT: next_raw = req_s2; // [R10]
         default: next_raw = 1'b0;
      endcase
      next_line = {dly_line[DLY_DEPTH-2:0], raw};
      // Both outputs draw on the same generated stream.
      next_main = frame_ref_delay_bypass ? raw : dly_line[dly_main]; // [R11] [R13] [R14]
      next_aux = o_aux_frame_ref;
      if (post_tick) begin
         next_aux = frame_ref_delay_bypass ? raw : dly_line[dly_aux]; // [R12] [R13]
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         raw <= 1'b0;
         dly_line <= '0;
         o_main_frame_ref <= 1'b0;
         o_aux_frame_ref <= 1'b0;
      end else begin
         raw <= next_raw;
         dly_line <= next_line;
         o_main_frame_ref <= next_main; // [R12]
         o_aux_frame_ref <= next_aux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   property p_reset_div;
      $past(i_rst) |-> (aux_prescaler == PRE_DEF) && (aux_post_divider == POST_DEF);
   endproperty
   a_reset_div: assert property (p_reset_div) else $error("divider defaults wrong after reset"); // [R4]

   property p_gen_pass;
      (frame_ref_mode_select == MODE_GEN && frame_ref_request_force) |=> (raw == $past(gen_level));
   endproperty
   a_gen_pass: assert property (p_gen_pass) else $error("continuous stream not passed"); // [R5]

   property p_gen_gate;
      (frame_ref_mode_select == MODE_GEN && !req_s2 && !frame_ref_request_force) |=> !raw;
   endproperty
   a_gen_gate: assert property (p_gen_gate) else $error("output not quiet while gated"); // [R7]

   property p_burst_end;
      (burst_state == BR_RUN && gen_tick && remain == 5'h01 && !sync_evt) |=> burst_state == BR_IDLE;
   endproperty
   a_burst_end: assert property (p_burst_end) else $error("burst did not end on last pulse"); // [R8]

   property p_burst_len;
      (burst_state == BR_WAIT && gen_tick && frame_ref_mode_select == MODE_BURST && !sync_evt)
         |=> (remain == {1'b0, $past(burst_pulse_count)} + 5'h01);
   endproperty
   a_burst_len: assert property (p_burst_len) else $error("burst length not loaded"); // [R8]

   property p_launch;
      (burst_state == BR_IDLE && frame_ref_mode_select == MODE_BURST && launch && !sync_evt)
         |=> burst_state == BR_WAIT;
   endproperty
   a_launch: assert property (p_launch) else $error("burst not launched"); // [R9]

   property p_repeat;
      (frame_ref_mode_select == MODE_REPEAT && i_frame_ref_request_pins) ##1
         (frame_ref_mode_select == MODE_REPEAT) ##1 (frame_ref_mode_select == MODE_REPEAT) |=> raw;
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeater did not follow pins"); // [R10]

   property p_aux_retime;
      !post_tick |=> $stable(o_aux_frame_ref);
   endproperty
   a_aux_retime: assert property (p_aux_retime) else $error("aux reference moved off clock edge"); // [R12]

   property p_single_rise;
      req_rise |=> !req_rise;
   endproperty
   a_single_rise: assert property (p_single_rise) else $error("request edge seen twice"); // [R17]

endmodule // acdrpg_top
`default_nettype wire

/* File: testbench/acdrpg_far_model.sv */
// Far-side model: request pin source and receiver of the frame references.
`timescale 1ns/1ps
`default_nettype none
module acdrpg_far_model (
   // Clock.
   input wire logic i_mclk,
   // References from the block.
   input wire logic i_main_frame_ref,
   input wire logic i_aux_frame_ref,
   // Request pin drive.
   output logic o_frame_ref_request_pins
);
   int main_edges;
   int aux_edges;
   logic main_q;
   logic aux_q;

   // The pins sit low until a scenario asks for a request, so the force bit is usable.
   initial begin
      o_frame_ref_request_pins = 1'b0;
      main_edges = 0;
      aux_edges = 0;
      main_q = 1'b0;
      aux_q = 1'b0;
   end

   // Output level and common-mode codes are board choices; this receiver takes any valid pair.
   always @(posedge i_mclk) begin
      main_q <= i_main_frame_ref;
      aux_q <= i_aux_frame_ref;
      if (i_main_frame_ref === 1'b1 && main_q === 1'b0) begin
         main_edges <= main_edges + 1;
      end
      if (i_aux_frame_ref === 1'b1 && aux_q === 1'b0) begin
         aux_edges <= aux_edges + 1;
      end
   end

   task automatic drive_pin(input logic v);
      @(posedge i_mclk);
      o_frame_ref_request_pins <= v;
   endtask
endmodule // acdrpg_far_model
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the aux divider and frame reference generator.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import acdrpg_pkg::*;
   logic i_mclk;
   logic i_rst;
   logic [ADDR_W-1:0] adr;
   logic rd_q;
   logic wr_q;
   logic [DATA_W-1:0] wd;
   logic [DATA_W-1:0] rdata;
   logic wreq;
   logic pins;
   logic sync_ev;
   logic aux_clk;
   logic main_ref;
   logic aux_ref;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;

   acdrpg_top acdrpg_top_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd_q),
      .i_avs_write(wr_q), .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .i_frame_ref_request_pins(pins), .i_sync_event(sync_ev), .o_aux_fabric_clock(aux_clk),
      .o_main_frame_ref(main_ref), .o_aux_frame_ref(aux_ref));
   acdrpg_far_model acdrpg_far_model_inst (.i_mclk(i_mclk), .i_main_frame_ref(main_ref),
      .i_aux_frame_ref(aux_ref), .o_frame_ref_request_pins(pins));

   always #10 i_mclk = ~i_mclk;
   always @(posedge i_mclk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   // The request stands until waitrequest is seen low at a rising edge, where read data are taken.
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge i_mclk);
      adr <= a;
      wr_q <= w;
      rd_q <= ~w;
      wd <= d;
      do begin
         @(posedge i_mclk);
      end while (wreq !== 1'b0);
      q = rdata;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(q === e, "register read mismatch");
   endtask

   task automatic win(input int n, output int m, output int x);
      int s;
      int t;
      s = acdrpg_far_model_inst.main_edges;
      t = acdrpg_far_model_inst.aux_edges;
      repeat (n) @(posedge i_mclk);
      m = acdrpg_far_model_inst.main_edges - s;
      x = acdrpg_far_model_inst.aux_edges - t;
   endtask

   task automatic aux_shape(output int hi, output int lo);
      hi = 0;
      lo = 0;
      @(negedge i_mclk);
      while (aux_clk !== 1'b0) @(negedge i_mclk);
      while (aux_clk !== 1'b1) @(negedge i_mclk);
      while (aux_clk === 1'b1) begin
         hi++;
         @(negedge i_mclk);
      end
      while (aux_clk === 1'b0) begin
         lo++;
         @(negedge i_mclk);
      end
   endtask

   task automatic first_rise(output int t);
      @(negedge i_mclk);
      // The first rise may follow the gate opening; the second marks the generator phase.
      repeat (2) begin
         while (main_ref !== 1'b0) @(negedge i_mclk);
         while (main_ref !== 1'b1) @(negedge i_mclk);
      end
      t = cyc;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      int hi;
      int lo;
      rd(OFF_AUXDIV, 32'h0020_0002);
      rd(OFF_REFDIV, 32'h0000_0040);
      rd(OFF_CTRL, 32'h0000_0000);
      wr(6'h1C, 32'hFFFF_FFFF);
      rd(6'h1C, 32'h0000_0000);
      aux_shape(hi, lo);
      chk(hi == 64 && lo == 64, "default aux clock shape");
   endtask

   task automatic t_aux();
      logic [1:0] code [3] = '{2'h0, 2'h1, 2'h3};
      int post [3] = '{5, 4, 3};
      int eh [3] = '{3, 4, 8};
      int el [3] = '{2, 4, 4};
      int hi;
      int lo;
      for (int i = 0; i < 3; i++) begin
         wr(OFF_AUXDIV, {6'h00, 10'(post[i]), 14'h0000, code[i]});
         aux_shape(hi, lo);
         chk(hi == eh[i] && lo == el[i], "aux clock duty");
      end
   endtask

   task automatic t_sync();
      int n [2];
      wr(OFF_AUXDIV, 32'h0006_0000);
      for (int k = 0; k < 2; k++) begin
         repeat (3 * k + 1) @(posedge i_mclk);
         if (k == 0) begin
            sync_ev <= 1'b1;
            @(posedge i_mclk);
            sync_ev <= 1'b0;
         end else begin
            wr(OFF_CTRL, 32'h0000_0010);
            @(posedge i_mclk);
         end
         n[k] = 0;
         @(negedge i_mclk);
         while (aux_clk === 1'b1 && n[k] < 20) begin
            n[k]++;
            @(negedge i_mclk);
         end
      end
      chk(n[0] == n[1] && n[0] > 0 && n[0] <= 4, "sync does not realign aux dividers");
      rd(OFF_CTRL, 32'h0000_0000);
   endtask

   task automatic t_gen();
      int m;
      int x;
      int t1;
      int t2;
      wr(OFF_AUXDIV, 32'h0002_0000);
      wr(OFF_REFDIV, 32'h0000_0008);
      wr(OFF_CTRL, 32'h0000_0008);
      win(40, m, x);
      chk(m == 0 && x == 0, "ungated generator output");
      wr(OFF_CTRL, 32'h0000_000C);
      repeat (20) @(posedge i_mclk);
      win(80, m, x);
      chk(m == 10, "continuous stream count");
      chk(x == 10, "aux reference from shared generator");
      wr(OFF_CTRL, 32'h0000_000F);
      repeat (4) @(posedge i_mclk);
      win(40, m, x);
      chk(m == 0 && x == 0, "reserved mode not quiet");
      wr(OFF_CTRL, 32'h0000_0008);
      acdrpg_far_model_inst.drive_pin(1'b1);
      first_rise(t1);
      acdrpg_far_model_inst.drive_pin(1'b0);
      repeat (37) @(posedge i_mclk);
      acdrpg_far_model_inst.drive_pin(1'b1);
      first_rise(t2);
      chk((t2 - t1) % 8 == 0, "gating disturbed generator phase");
      acdrpg_far_model_inst.drive_pin(1'b0);
   endtask

   task automatic t_burst();
      int cnt [3] = '{0, 3, 15};
      int m;
      int x;
      logic [31:0] q;
      wr(OFF_REFDIV, 32'h0000_0004);
      for (int i = 0; i < 3; i++) begin
         wr(OFF_BURST, 32'(cnt[i]));
         wr(OFF_CTRL, 32'h0000_0009);
         wr(OFF_CTRL, 32'h0000_000D);
         win(110, m, x);
         chk(m == cnt[i] + 1, "burst length from force");
      end
      wr(OFF_CTRL, 32'h0000_0009);
      wr(OFF_BURST, 32'h0000_0002);
      acdrpg_far_model_inst.drive_pin(1'b1);
      win(60, m, x);
      chk(m == 3, "burst length from pin edge");
      wr(OFF_CTRL, 32'h0000_000D);
      win(60, m, x);
      chk(m == 0, "burst while pin held high");
      bus(1'b0, OFF_STATUS, 32'h0000_0000, q);
      chk((q & 32'h0000_0003) == 32'h0000_0001, "status request or busy bit");
      acdrpg_far_model_inst.drive_pin(1'b0);
      wr(OFF_CTRL, 32'h0000_0009);
   endtask

   task automatic lat(output int n);
      acdrpg_far_model_inst.drive_pin(1'b1);
      n = 0;
      @(negedge i_mclk);
      while (main_ref !== 1'b1 && n < 40) begin
         n++;
         @(negedge i_mclk);
      end
      acdrpg_far_model_inst.drive_pin(1'b0);
      repeat (15) @(posedge i_mclk);
      chk(main_ref === 1'b0, "repeater output stuck high");
   endtask

   task automatic t_rep();
      int n1;
      int n2;
      wr(OFF_CTRL, 32'h0000_000A);
      repeat (5) @(posedge i_mclk);
      lat(n1);
      chk(n1 >= 3 && n1 <= 5, "repeater latency");
      wr(OFF_DELAY, 32'h0000_0002);
      wr(OFF_CTRL, 32'h0000_0002);
      repeat (5) @(posedge i_mclk);
      lat(n2);
      chk(n2 - n1 == 3, "delay path not applied");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      i_mclk = 1'b0;
      i_rst = 1'b1;
      adr = '0;
      rd_q = 1'b0;
      wr_q = 1'b0;
      wd = '0;
      sync_ev = 1'b0;
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'b0;
      t_reset();
      t_aux();
      t_sync();
      t_gen();
      t_burst();
      t_rep();
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge i_mclk);
      error_cnt++;
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
